// [rtl/power_mode_and_reset_entry.sv]
// Power-mode and reset-entry controller for the processor core
// Function
// - Idle bit written one halts the CPU after that instruction; peripherals run.
// - Idle preserves every internal register and memory location.
// - Enabled interrupt in idle clears idle, resumes CPU, services it.
// - Reset ending idle runs normal reset and restarts at 0x0000.
// - Enabled watchdog keeps running in idle; overflow resets out of it.
// - Stop bit written one stops CPU, oscillator, peripherals; detector stays.
// - Only a reset leaves stop; restart at 0x0000 after normal sequence.
// - Stop and idle bits read zero; reserved bits read zero.
// - Reset halts execution, resets registers, forces ports, disables timers.
// - Reset leaves data memory alone; stack pointer is reinitialised.
// - Port latches go to 0xFF during reset within four cycles.
// - Supply-monitor reset drives reset pin low until its timeout ends.
// - Reset exit clears PC, selects default clock, watchdog longest interval.
// - Fetch from 0x0000 starts only once the system clock is stable.
// - Eight listed sources each place the device into reset.
// - Missing clock detector resets without touching the reset pin.
module power_mode_and_reset_entry
    import pm_pkg::*;
#(
    parameter int WDT_EXP_OFFSET = pm_pkg::WDT_EXP_OFFSET
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sfr_wr_en,
    input  wire logic        sfr_rd_en,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    input  wire logic        insn_done,
    input  wire logic        int_req,
    input  wire logic        sw_reset_req,
    input  wire logic        cnv_reset_en,
    input  wire logic        cmp0_reset_en,
    input  wire logic        mcd_en,
    input  wire logic        rst_pin_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    input  wire logic        cnv_reset_in_n,
    input  wire logic        cmp0_out,
    input  wire logic        supply_low,
    input  wire logic        vmon_timeout_done,
    input  wire logic        osc_stable,
    input  wire logic        mcd_timeout,
    output logic             cpu_clk_en,
    output logic             periph_clk_en,
    output logic             osc_run,
    output logic             sfr_reset,
    output logic             port_latch_force,
    output logic [7:0]       port_latch_value,
    output logic             fetch_en,
    output logic             sysclk_default,
    output logic [15:0]      restart_addr,
    output logic             wdt_active
);
    import pm_pkg::*;

    // ==========================================================
    // Pin synchroniser lanes
    localparam int S_RST = 0;
    localparam int S_CNV = 1;
    localparam int S_CMP = 2;
    localparam int S_SUP = 3;
    localparam int S_VTO = 4;
    localparam int S_OSC = 5;
    localparam int S_MCD = 6;
    localparam int NSYNC = 7;

    typedef struct packed {
        logic [NSYNC-1:0] sync1;
        logic [NSYNC-1:0] sync2;
        pm_state_t        state;
        logic             idle_req;
        logic             stop_req;
        logic [3:0]       hold_cnt;
        logic             vmon_hold;
        logic [7:0]       rdata;
        logic             cpu_clk_en;
        logic             periph_clk_en;
        logic             osc_run;
        logic             sfr_reset;
        logic             port_force;
        logic [7:0]       port_value;
        logic             rst_pin_oe;
        logic             fetch_en;
        logic             clk_default;
        logic [15:0]      restart_addr;
    } pm_st_t;

    pm_st_t st_r;
    pm_st_t st_nxt;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] s;
    logic             reset_any;
    logic             wdt_ovf;
    logic             wdt_act;
    logic [2:0]       wdt_int;
    logic             power_mode_control_wr;
    logic             wdt_wr;

    assign pins = {mcd_timeout, osc_stable, vmon_timeout_done,
                   supply_low, cmp0_out, cnv_reset_in_n, rst_pin_in};
    assign s = st_r.sync2;
    assign power_mode_control_wr = sfr_wr_en && (sfr_addr == POWER_MODE_CONTROL_ADDR);
    assign wdt_wr = sfr_wr_en && (sfr_addr == WATCHDOG_CTRL_ADDR);

    // ==========================================================
    // Reset sources
    assign reset_any = !s[S_RST]
                     || (cnv_reset_en && !s[S_CNV])
                     || sw_reset_req
                     || (cmp0_reset_en && !s[S_CMP])
                     || (mcd_en && s[S_MCD])
                     || wdt_ovf
                     || s[S_SUP]
                     || st_r.vmon_hold;

    watchdog_timer #(
        .EXP_OFFSET (WDT_EXP_OFFSET)
    ) u_wdt (
        .clk       (clk),
        .rst_n     (rst_n),
        .sys_reset (st_r.sfr_reset),
        .halt      (st_r.state == ST_STOP),
        .wr_en     (wdt_wr),
        .wdata     (sfr_wdata),
        .active    (wdt_act),
        .interval  (wdt_int),
        .overflow  (wdt_ovf)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = pins;
        st_nxt.sync2 = st_r.sync1;
        // Supply monitor holds the pin until its own timeout ends
        if (s[S_SUP])
            st_nxt.vmon_hold = 1'b1;
        else if (s[S_VTO])
            st_nxt.vmon_hold = 1'b0;
        st_nxt.rst_pin_oe = st_nxt.vmon_hold || s[S_SUP];
        st_nxt.rdata = 8'h00;
        if (sfr_rd_en && sfr_addr == POWER_MODE_CONTROL_ADDR)
            st_nxt.rdata = POWER_MODE_CONTROL_RESET;
        else if (sfr_rd_en && sfr_addr == WATCHDOG_CTRL_ADDR)
        begin
            st_nxt.rdata[WDT_STATUS_BIT] = wdt_act;
            st_nxt.rdata[2:0] = wdt_int;
        end
        if (power_mode_control_wr && st_r.state == ST_RUN)
        begin
            st_nxt.idle_req = st_r.idle_req || sfr_wdata[IDLE_SEL_BIT];
            st_nxt.stop_req = st_r.stop_req || sfr_wdata[STOP_SEL_BIT];
        end
        if (reset_any)
        begin
            // Any source, any state: idle and stop end here too
            st_nxt.state = ST_RESET;
            st_nxt.hold_cnt = RESET_HOLD_CYCLES;
        end
        else
        begin
            case (st_r.state)
                ST_RESET:
                    if (st_r.hold_cnt != 4'h0)
                        st_nxt.hold_cnt = st_r.hold_cnt - 4'h1;
                    else
                        st_nxt.state = ST_WAIT_CLK;
                ST_WAIT_CLK:
                    if (s[S_OSC])
                        st_nxt.state = ST_RUN;
                ST_RUN:
                    if (insn_done && st_nxt.stop_req)
                        st_nxt.state = ST_STOP;
                    else if (insn_done && st_nxt.idle_req)
                        st_nxt.state = ST_IDLE;
                ST_IDLE:
                    if (int_req)
                        st_nxt.state = ST_RUN;
                ST_STOP:
                    // Interrupts ignored; only a reset gets out
                    st_nxt.state = ST_STOP;
                default:
                    st_nxt.state = ST_RESET;
            endcase
        end
        if (st_nxt.state != ST_RUN)
        begin
            st_nxt.idle_req = 1'b0;
            st_nxt.stop_req = 1'b0;
        end
        else if (st_r.state != ST_RUN)
        begin
            st_nxt.idle_req = 1'b0;
            st_nxt.stop_req = 1'b0;
        end
        // Outputs follow the next state so they switch with it
        st_nxt.sfr_reset = (st_nxt.state == ST_RESET);
        st_nxt.port_force = (st_nxt.state == ST_RESET);
        st_nxt.port_value = PORT_LATCH_RESET;
        // CPU clock gated only: memory is never reset or written
        st_nxt.cpu_clk_en = (st_nxt.state == ST_RUN);
        st_nxt.periph_clk_en = (st_nxt.state == ST_RUN)
                            || (st_nxt.state == ST_IDLE);
        st_nxt.osc_run = (st_nxt.state != ST_STOP);
        st_nxt.clk_default = (st_nxt.state == ST_RESET)
                          || (st_nxt.state == ST_WAIT_CLK);
        st_nxt.fetch_en = (st_nxt.state == ST_RUN)
                       || (st_nxt.state == ST_IDLE);
        st_nxt.restart_addr = RESTART_ADDR;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.state <= ST_RESET;
            st_r.hold_cnt <= RESET_HOLD_CYCLES;
            st_r.vmon_hold <= 1'b1;
            st_r.rst_pin_oe <= 1'b1;
            st_r.sfr_reset <= 1'b1;
            st_r.port_force <= 1'b1;
            st_r.port_value <= PORT_LATCH_RESET;
            st_r.osc_run <= 1'b1;
            st_r.clk_default <= 1'b1;
            // Idle pin levels, so no false reset request follows reset
            st_r.sync1 <= 7'h07;
            st_r.sync2 <= 7'h07;
            st_r.restart_addr <= RESTART_ADDR;
        end
        else
            st_r <= st_nxt;
    end

    assign sfr_rdata = st_r.rdata;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe = st_r.rst_pin_oe;
    assign cpu_clk_en = st_r.cpu_clk_en;
    assign periph_clk_en = st_r.periph_clk_en;
    assign osc_run = st_r.osc_run;
    assign sfr_reset = st_r.sfr_reset;
    assign port_latch_force = st_r.port_force;
    assign port_latch_value = st_r.port_value;
    assign fetch_en = st_r.fetch_en;
    assign sysclk_default = st_r.clk_default;
    assign restart_addr = st_r.restart_addr;
    assign wdt_active = wdt_act;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_idle_entry;
        (st_r.state == ST_RUN && insn_done && !reset_any
         && (st_r.idle_req || (power_mode_control_wr && sfr_wdata[IDLE_SEL_BIT]))
         && !st_r.stop_req && !(power_mode_control_wr && sfr_wdata[STOP_SEL_BIT]))
        |=> (st_r.state == ST_IDLE) && !cpu_clk_en && periph_clk_en;
    endproperty
    a_idle_entry: assert property (p_idle_entry)
        else $error("idle not entered after write");

    property p_idle_wake;
        (st_r.state == ST_IDLE && int_req && !reset_any)
        |=> cpu_clk_en ##1 (st_r.idle_req == 1'b0);
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("idle not left on interrupt");

    property p_stop_entry;
        (st_r.state == ST_RUN && (st_r.stop_req || (power_mode_control_wr
         && sfr_wdata[STOP_SEL_BIT])) && insn_done && !reset_any)
        |=> (st_r.state == ST_STOP) && !osc_run && !periph_clk_en;
    endproperty
    a_stop_entry: assert property (p_stop_entry)
        else $error("stop not entered");

    property p_stop_hold;
        (st_r.state == ST_STOP && !reset_any) |=> st_r.state == ST_STOP;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop left without reset");

    property p_reads_zero;
        (sfr_rd_en && sfr_addr == POWER_MODE_CONTROL_ADDR)
        |=> sfr_rdata == 8'h00;
    endproperty
    a_reads_zero: assert property (p_reads_zero)
        else $error("power mode register read nonzero");

    property p_port_force;
        reset_any |=> port_latch_force && sfr_reset && !cpu_clk_en
                      && port_latch_value == 8'hFF;
    endproperty
    a_port_force: assert property (p_port_force)
        else $error("reset did not force ports");

    property p_pin_low;
        (s[S_SUP] || (st_r.vmon_hold && !s[S_VTO])) |=> rst_pin_oe;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("reset pin not driven on supply reset");

    property p_mcd_pin;
        (mcd_en && s[S_MCD] && !st_r.vmon_hold && !s[S_SUP])
        |=> !rst_pin_oe && sfr_reset;
    endproperty
    a_mcd_pin: assert property (p_mcd_pin)
        else $error("detector reset touched reset pin");

    property p_fetch_stable;
        $rose(fetch_en) |-> $past(s[S_OSC]) && restart_addr == 16'h0000
                            && $past(sysclk_default);
    endproperty
    a_fetch_stable: assert property (p_fetch_stable)
        else $error("fetch began before clock stable");

    c_idle_wake: cover property (st_r.state == ST_IDLE ##[1:50]
                                 st_r.state == ST_RUN);
    c_stop_reset: cover property (st_r.state == ST_STOP ##[1:50]
                                  st_r.state == ST_RESET);
    c_wdt_reset: cover property (wdt_ovf ##1 sfr_reset);
endmodule

// [rtl/pm_pkg.sv]
// Constants and types shared by the power-mode and reset-entry block
package pm_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0]  POWER_MODE_CONTROL_ADDR  = 8'h87;
    localparam logic [7:0]  POWER_MODE_CONTROL_RESET = 8'h00;
    localparam int          IDLE_SEL_BIT             = 0;
    localparam int          STOP_SEL_BIT             = 1;
    localparam logic [7:0]  WATCHDOG_CTRL_ADDR       = 8'hFF;
    // ==========================================================
    // Reset behaviour
    localparam logic [15:0] RESTART_ADDR             = 16'h0000;
    localparam logic [7:0]  PORT_LATCH_RESET         = 8'hFF;
    localparam logic [3:0]  RESET_HOLD_CYCLES        = 4'hC;
    // ==========================================================
    // Watchdog commands and fields
    localparam logic [7:0]  WDT_CMD_KICK             = 8'hA5;
    localparam logic [7:0]  WDT_CMD_DISABLE_1        = 8'hDE;
    localparam logic [7:0]  WDT_CMD_DISABLE_2        = 8'hAD;
    localparam logic [7:0]  WDT_CMD_LOCK             = 8'hFF;
    localparam logic [2:0]  WDT_DISABLE_WINDOW       = 3'h4;
    localparam logic [2:0]  WDT_INTERVAL_RESET       = 3'h7;
    localparam int          WDT_EXP_OFFSET           = 3;
    localparam int          WDT_CTRL_BIT             = 7;
    localparam int          WDT_STATUS_BIT           = 4;
    localparam int          WDT_CNT_W                = 22;
    // ==========================================================
    // Controller states
    typedef enum logic [2:0] {
        ST_RESET,
        ST_WAIT_CLK,
        ST_RUN,
        ST_IDLE,
        ST_STOP
    } pm_state_t;
endpackage

// [rtl/watchdog_timer.sv]
// Watchdog timer with kick, two-write disable, lockout and interval
module watchdog_timer
    import pm_pkg::*;
#(
    parameter int EXP_OFFSET = pm_pkg::WDT_EXP_OFFSET
)(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sys_reset,
    input  wire logic       halt,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic            active,
    output logic [2:0]      interval,
    output logic            overflow
);
    import pm_pkg::*;

    typedef struct packed {
        logic                 en;
        logic                 locked;
        logic [2:0]           interval;
        logic [WDT_CNT_W-1:0] cnt;
        logic [2:0]           dis_win;
        logic                 overflow;
    } wdt_st_t;

    wdt_st_t st_r;
    wdt_st_t st_nxt;
    logic [WDT_CNT_W-1:0] limit;
    logic [5:0]           shamt;

    // ==========================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        shamt = 6'(2 * EXP_OFFSET) + {2'b00, st_r.interval, 1'b0};
        limit = (WDT_CNT_W'(1) << shamt) - WDT_CNT_W'(1);
        st_nxt.overflow = 1'b0;
        if (st_r.dis_win != 3'h0)
            st_nxt.dis_win = st_r.dis_win - 3'h1;
        if (sys_reset)
        begin
            // Enabled with the longest interval on every reset
            st_nxt.en = 1'b1;
            st_nxt.locked = 1'b0;
            st_nxt.interval = WDT_INTERVAL_RESET;
            st_nxt.cnt = '0;
            st_nxt.dis_win = 3'h0;
        end
        else
        begin
            // Frozen in stop: its clock is gone there
            if (st_r.en && !halt)
            begin
                if (st_r.cnt == limit)
                begin
                    st_nxt.overflow = 1'b1;
                    st_nxt.cnt = '0;
                end
                else
                    st_nxt.cnt = st_r.cnt + WDT_CNT_W'(1);
            end
            if (wr_en)
            begin
                if (wdata == WDT_CMD_KICK)
                begin
                    st_nxt.en = 1'b1;
                    st_nxt.cnt = '0;
                end
                else if (wdata == WDT_CMD_DISABLE_1)
                    st_nxt.dis_win = WDT_DISABLE_WINDOW;
                else if (wdata == WDT_CMD_DISABLE_2)
                begin
                    if (st_r.dis_win != 3'h0 && !st_r.locked)
                        st_nxt.en = 1'b0;
                    st_nxt.dis_win = 3'h0;
                end
                else if (wdata == WDT_CMD_LOCK)
                    st_nxt.locked = 1'b1;
                else if (!wdata[WDT_CTRL_BIT])
                    st_nxt.interval = wdata[2:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.en <= 1'b1;
            st_r.interval <= WDT_INTERVAL_RESET;
        end
        else
            st_r <= st_nxt;
    end

    assign active = st_r.en;
    assign interval = st_r.interval;
    assign overflow = st_r.overflow;
endmodule

// [testbench/core_model.sv]
// Behavioural model of the processor core facing the block
module core_model
    import pm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cpu_clk_en,
    input  wire logic        fetch_en,
    input  wire logic [15:0] restart_addr,
    output logic             insn_done,
    output logic [15:0]      pc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic fetch_d_r;
    // ==========================================================
    // Instruction stream
    // One-cycle instructions, so an idle write is never followed
    // by a short single-byte one
    assign insn_done = cpu_clk_en & fetch_en;
    // Not reset to the restart address, so a reload is visible
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fetch_d_r <= 1'b0;
            pc        <= 16'hFFFF;
        end
        else
        begin
            fetch_d_r <= fetch_en;
            if (fetch_en && !fetch_d_r)
                pc <= restart_addr;
            else if (insn_done)
                pc <= pc + 16'h0001;
        end
    end
endmodule

// [testbench/test_power_mode_and_reset_entry.sv]
// Self-checking bench for the power-mode and reset-entry block
module test_power_mode_and_reset_entry;
    timeunit 1ns;
    timeprecision 100ps;
    import pm_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, sfr_wr_en = 1'b0;
    logic        sfr_rd_en = 1'b0, int_req = 1'b0, sw_reset_req = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic        cnv_reset_en = 1'b0, cmp0_reset_en = 1'b0;
    logic        mcd_en = 1'b0, ext_rst_n = 1'b1, cnv_reset_in_n = 1'b1;
    logic        cmp0_out = 1'b1, supply_low = 1'b0, mcd_timeout = 1'b0;
    logic        vmon_timeout_done = 1'b0, osc_stable = 1'b0;
    logic        rst_pin_in, rst_pin_out, rst_pin_oe, insn_done;
    logic        cpu_clk_en, periph_clk_en, osc_run, sfr_reset;
    logic        port_latch_force, fetch_en, sysclk_default, wdt_active;
    logic [7:0]  port_latch_value, rd;
    logic [15:0] restart_addr, pc;
    int          num_errors = 0, n_tests = 0, n;
    always #20 clk = ~clk;
    // Open-drain reset wire, pulled up
    assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) & ext_rst_n;
    power_mode_and_reset_entry #(.WDT_EXP_OFFSET(0)) uut (.clk(clk),
        .rst_n(rst_n), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .insn_done(insn_done), .int_req(int_req),
        .sw_reset_req(sw_reset_req), .cnv_reset_en(cnv_reset_en),
        .cmp0_reset_en(cmp0_reset_en), .mcd_en(mcd_en),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .cnv_reset_in_n(cnv_reset_in_n),
        .cmp0_out(cmp0_out), .supply_low(supply_low),
        .vmon_timeout_done(vmon_timeout_done), .osc_stable(osc_stable),
        .mcd_timeout(mcd_timeout), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_run(osc_run),
        .sfr_reset(sfr_reset), .port_latch_force(port_latch_force),
        .port_latch_value(port_latch_value), .fetch_en(fetch_en),
        .sysclk_default(sysclk_default), .restart_addr(restart_addr),
        .wdt_active(wdt_active));
    core_model partner (.clk(clk), .rst_n(rst_n), .cpu_clk_en(cpu_clk_en),
        .fetch_en(fetch_en), .restart_addr(restart_addr),
        .insn_done(insn_done), .pc(pc));
    // ==========================================================
    // Shared tasks
    task close_out;
    begin
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task check(input string name, input logic [15:0] seen, exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task sfr_write(input logic [7:0] a, d);
    begin
        @(posedge clk);
        sfr_wr_en <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr_en <= 1'b0;
        #1;
    end
    endtask
    task sfr_read(input logic [7:0] a);
    begin
        @(posedge clk);
        sfr_rd_en <= 1'b1;
        sfr_addr  <= a;
        @(posedge clk);
        sfr_rd_en <= 1'b0;
        #1 rd = sfr_rdata;
    end
    endtask
    // Bounded waits; a wait that runs out ends the run
    task wait_run;
    begin
        n = 0;
        while (!(fetch_en === 1'b1 && cpu_clk_en === 1'b1) && n < 300)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 300)
        begin
            num_errors++;
            close_out;
        end
    end
    endtask
    task wait_rst(input int bound);
    begin
        n = 0;
        #1;
        while (sfr_reset !== 1'b1 && n < bound)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= bound)
        begin
            num_errors++;
            close_out;
        end
    end
    endtask
    task boot;
    begin
        osc_stable <= 1'b0;
        repeat (40) @(posedge clk);
        #1 check("fetch_en", fetch_en, 1'b0);
        check("sysclk_default", sysclk_default, 1'b1);
        @(posedge clk) osc_stable <= 1'b1;
        wait_run;
        @(posedge clk) #1 check("pc", pc, RESTART_ADDR);
        check("wdt_active", wdt_active, 1'b1);
    end
    endtask
    // ==========================================================
    // Scenarios
    task t_reset_state;
    begin
        #1 check("sfr_reset", sfr_reset, 1'b1);
        check("cpu_clk_en", cpu_clk_en, 1'b0);
        check("port_force", port_latch_force, 1'b1);
        check("port_value", port_latch_value, 8'hFF);
        check("rst_pin_oe", rst_pin_oe, 1'b1);
        check("rst_pin_out", rst_pin_out, 1'b0);
        @(posedge clk) rst_n <= 1'b1;
        vmon_timeout_done <= 1'b1;
        boot;
        sfr_read(WATCHDOG_CTRL_ADDR);
        check("wdt_reg", rd, 8'h17);
        sfr_read(POWER_MODE_CONTROL_ADDR);
        check("pmc_reset", rd, POWER_MODE_CONTROL_RESET);
        sfr_read(8'h10);
        check("unmapped", rd, 8'h00);
    end
    endtask
    task t_idle;
    begin
        sfr_write(POWER_MODE_CONTROL_ADDR, 8'h01);
        check("idle_cpu", cpu_clk_en, 1'b0);
        check("idle_periph", periph_clk_en, 1'b1);
        check("idle_osc", osc_run, 1'b1);
        sfr_read(POWER_MODE_CONTROL_ADDR);
        check("pmc_idle", rd, 8'h00);
        @(posedge clk) int_req <= 1'b1;
        wait_run;
        @(posedge clk) int_req <= 1'b0;
        #1 check("wake_no_reset", sfr_reset, 1'b0);
        sfr_read(WATCHDOG_CTRL_ADDR);
        check("wdt_kept", rd, 8'h17);
    end
    endtask
    task t_stop;
    begin
        @(posedge clk) mcd_en <= 1'b0;
        sfr_write(POWER_MODE_CONTROL_ADDR, 8'h03);
        check("stop_cpu", cpu_clk_en, 1'b0);
        check("stop_osc", osc_run, 1'b0);
        check("stop_periph", periph_clk_en, 1'b0);
        @(posedge clk) int_req <= 1'b1;
        repeat (5) @(posedge clk);
        #1 check("stop_int_osc", osc_run, 1'b0);
        check("stop_int_cpu", cpu_clk_en, 1'b0);
        @(posedge clk) int_req <= 1'b0;
        sw_reset_req <= 1'b1;
        wait_rst(10);
        @(posedge clk) sw_reset_req <= 1'b0;
        boot;
    end
    endtask
    task t_sources;
    begin
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            case (k)
                0: sw_reset_req <= 1'b1;
                1: ext_rst_n <= 1'b0;
                2: {cnv_reset_en, cnv_reset_in_n} <= 2'b10;
                3: {cmp0_reset_en, cmp0_out} <= 2'b10;
                4: {mcd_en, mcd_timeout} <= 2'b11;
                default:
                begin
                    supply_low <= 1'b1;
                    vmon_timeout_done <= 1'b0;
                end
            endcase
            wait_rst(10);
            check("latency_ok", n <= 4, 1'b1);
            check("src_force", port_latch_force, 1'b1);
            check("src_pin_oe", rst_pin_oe, k == 5);
            @(posedge clk);
            {sw_reset_req, supply_low, mcd_timeout, mcd_en} <= 4'h0;
            {ext_rst_n, cnv_reset_in_n, cmp0_out} <= 3'h7;
            {cnv_reset_en, cmp0_reset_en} <= 2'h0;
            // Pin must stay driven past supply recovery until timeout
            if (k == 5)
            begin
                repeat (6) @(posedge clk);
                #1 check("pin_held", rst_pin_oe, 1'b1);
                @(posedge clk) vmon_timeout_done <= 1'b1;
            end
            boot;
        end
    end
    endtask
    task t_wdog;
    begin
        sfr_write(WATCHDOG_CTRL_ADDR, WDT_CMD_KICK);
        sfr_write(WATCHDOG_CTRL_ADDR, 8'h02);
        sfr_write(WATCHDOG_CTRL_ADDR, WDT_CMD_KICK);
        sfr_read(WATCHDOG_CTRL_ADDR);
        check("wdt_interval", rd, 8'h12);
        sfr_write(POWER_MODE_CONTROL_ADDR, 8'h01);
        wait_rst(40);
        boot;
        sfr_write(WATCHDOG_CTRL_ADDR, WDT_CMD_DISABLE_1);
        sfr_write(WATCHDOG_CTRL_ADDR, WDT_CMD_DISABLE_2);
        check("wdt_off", wdt_active, 1'b0);
    end
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        t_reset_state;
        t_idle;
        t_stop;
        t_sources;
        t_wdog;
        close_out;
    end
endmodule
